//--- inc/igca_defines.vh
`ifndef IGCA_DEFINES_VH
`define IGCA_DEFINES_VH
// Register byte addresses.
`define IGCA_ADDR_SRC      8'h00
`define IGCA_ADDR_FPCMD    8'h04
`define IGCA_ADDR_LOWLIM   8'h08
`define IGCA_ADDR_EDITSEL  8'h0C
`define IGCA_ADDR_SETTINGS 8'h10
`define IGCA_ADDR_STATUS   8'h14
`define IGCA_ADDR_PRES     8'h18
// Front-panel command bit positions.
`define IGCA_FP_FIL_ON     0
`define IGCA_FP_FIL_OFF    1
`define IGCA_FP_EMIS_4MA   2
`define IGCA_FP_EMIS_LOW   3
`define IGCA_FP_DEGAS_ON   4
`define IGCA_FP_DEGAS_OFF  5
`define IGCA_FP_FAULT_CLR  6
// Control source encodings.
`define IGCA_SRC_COMBINED  1'b0
`define IGCA_SRC_PANEL     1'b1
// Serial command codes.
`define IGCA_SER_FIL_ON    3'h0
`define IGCA_SER_FIL_OFF   3'h1
`define IGCA_SER_DEG_ON    3'h2
`define IGCA_SER_DEG_OFF   3'h3
`define IGCA_SER_SET_EMIS  3'h4
`define IGCA_SER_READ      3'h5
`define IGCA_SER_RESET     3'h6
// Edit targets of the front-panel keys.
`define IGCA_EDIT_CONTRAST 2'h0
`define IGCA_EDIT_GAS      2'h1
`define IGCA_EDIT_UNIT     2'h2
`define IGCA_EDIT_MODE     2'h3
// Setting ranges and reset values.
`define IGCA_CONTRAST_MIN  7'h01
`define IGCA_CONTRAST_MAX  7'h78
`define IGCA_CONTRAST_RST  7'h0A
`define IGCA_GAS_LAST      7'h0F
`define IGCA_GAS_RST       4'h0
`define IGCA_UNIT_LAST     7'h02
`define IGCA_UNIT_RST      2'h0
`define IGCA_MODE_RST      1'b0
// Pressure limits in units of 1e-6 torr.
`define IGCA_LIM_4MA       16'h03E8
`define IGCA_LIM_LOW_MAX   16'hC350
// Display field masks: filcur,filvolt,ion,emis,relay1,fil,gas,unit,pressure.
`define IGCA_DISP_STD      9'h01F
`define IGCA_DISP_DIAG     9'h1E1
`endif

//--- design/igca_arbiter.v
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "igca_defines.vh"
module igca_arbiter
(
	input  wire        mclk,
	input  wire        rstn,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire        din_fil_n,
	input  wire        din_emis_n,
	input  wire        din_degas_n,
	input  wire        key_up_n,
	input  wire        key_down_n,
	input  wire        key_enter_n,
	input  wire        ser_cmd_valid,
	input  wire [2:0]  ser_cmd_code,
	input  wire        ser_cmd_arg,
	input  wire        pres_valid,
	input  wire [15:0] pres_value,
	input  wire        emis_fail,
	output reg         fil_on,
	output reg         degas_on,
	output reg         emis_4ma,
	output reg         measure_en,
	output reg         fault_msg,
	output reg         serial_mode,
	output reg  [8:0]  disp_fields,
	output reg  [6:0]  contrast,
	output reg  [3:0]  gas_sel,
	output reg  [1:0]  unit_sel
);

	reg  [5:0]  in_s1_reg;
	reg  [5:0]  in_s2_reg;
	reg  [5:0]  in_s3_reg;
	reg  [5:0]  in_st_reg;
	reg  [2:0]  key_prev_reg;
	reg  [2:0]  key_hit_reg;
	reg         src_reg;
	reg         ser_reg;
	reg         fil_reg;
	reg         deg_reg;
	reg         em_reg;
	reg         fault_reg;
	reg  [15:0] lowlim_reg;
	reg  [15:0] pres_reg;
	reg  [1:0]  sel_reg;
	reg  [6:0]  edit_reg;
	reg  [6:0]  con_reg;
	reg  [3:0]  gas_reg;
	reg  [1:0]  unit_reg;
	reg         mode_reg;
	reg         src_next;
	reg         ser_next;
	reg         fil_next;
	reg         deg_next;
	reg         em_next;
	reg  [6:0]  edit_next;
	reg  [6:0]  cur_val;
	reg  [31:0] rdata_next;
	wire [5:0]  in_agree;
	wire [5:0]  in_st_next;
	wire        fp_wr;
	wire [6:0]  fp_cmd;
	wire        ctrl_cmd;
	wire [15:0] trip_lim;
	wire        over_pres;
	wire        fault_set;
	wire        fault_clr;
	wire        allow_on;
	wire [15:0] lim_wr;

	// Pins pass three flops; a level counts once the second and third agree.
	assign in_agree   = ~(in_s2_reg ^ in_s3_reg);
	assign in_st_next = (in_agree & in_s3_reg) | (~in_agree & in_st_reg);

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			in_s1_reg    <= 6'h3F;
			in_s2_reg    <= 6'h3F;
			in_s3_reg    <= 6'h3F;
			in_st_reg    <= 6'h3F;
			key_prev_reg <= 3'h7;
			key_hit_reg  <= 3'h0;
		end
		else
		begin
			in_s1_reg    <= {key_enter_n, key_down_n, key_up_n,
			                 din_degas_n, din_emis_n, din_fil_n};
			in_s2_reg    <= in_s1_reg;
			in_s3_reg    <= in_s2_reg;
			in_st_reg    <= in_st_next;
			key_prev_reg <= in_st_reg[5:3];
			key_hit_reg  <= key_prev_reg & ~in_st_reg[5:3]; // Press on falling level.
		end
	end

	// Panel command pulses and the trip decision for this sample.
	assign fp_wr     = wr && (addr == `IGCA_ADDR_FPCMD);
	assign fp_cmd    = fp_wr ? wdata[6:0] : 7'h00;
	assign ctrl_cmd  = ser_cmd_valid && (ser_cmd_code <= `IGCA_SER_SET_EMIS);
	assign trip_lim  = em_reg ? `IGCA_LIM_4MA : lowlim_reg;
	assign over_pres = pres_valid && (pres_value > trip_lim);
	assign fault_set = over_pres | emis_fail;
	assign fault_clr = fp_cmd[`IGCA_FP_FAULT_CLR];
	assign allow_on  = !fault_reg && (!em_next || (pres_reg <= `IGCA_LIM_4MA));
	assign lim_wr    = (wdata[15:0] > `IGCA_LIM_LOW_MAX) ? `IGCA_LIM_LOW_MAX
	                                                      : wdata[15:0];

	// Arbitration of the filament, emission and degas between the sources.
	always @*
	begin
		src_next = src_reg;
		ser_next = ser_reg;
		fil_next = fil_reg;
		deg_next = deg_reg;
		em_next  = em_reg;
		if (src_reg == `IGCA_SRC_PANEL)
		begin
			// Discrete and serial inputs have no effect here.
			if (fp_cmd[`IGCA_FP_FIL_ON])
				fil_next = 1'b1;
			if (fp_cmd[`IGCA_FP_FIL_OFF])
				fil_next = 1'b0;
			if (fp_cmd[`IGCA_FP_EMIS_4MA])
				em_next = 1'b1;
			if (fp_cmd[`IGCA_FP_EMIS_LOW])
				em_next = 1'b0;
			if (fp_cmd[`IGCA_FP_DEGAS_ON] && fil_reg)
				deg_next = 1'b1;
			if (fp_cmd[`IGCA_FP_DEGAS_OFF])
				deg_next = 1'b0;
		end
		else
		begin
			if (!ser_reg)
			begin
				// Discrete levels steer the gauge only in the discrete state.
				em_next  = !in_st_reg[1];
				fil_next = !in_st_reg[0];
				deg_next = !in_st_reg[2] && fil_reg;
			end
			if (ctrl_cmd)
			begin
				if (!ser_reg)
				begin
					// Safe state on takeover: degas off, filament as it stood.
					ser_next = 1'b1;
					fil_next = fil_reg;
					deg_next = 1'b0;
					em_next  = em_reg;
				end
				case (ser_cmd_code)
					`IGCA_SER_FIL_ON:   fil_next = 1'b1;
					`IGCA_SER_FIL_OFF:  fil_next = 1'b0;
					`IGCA_SER_DEG_ON:   deg_next = fil_reg;
					`IGCA_SER_DEG_OFF:  deg_next = 1'b0;
					`IGCA_SER_SET_EMIS: em_next  = ser_cmd_arg;
					default:            deg_next = deg_next;
				endcase
			end
			if (ser_cmd_valid && (ser_cmd_code == `IGCA_SER_RESET))
				ser_next = 1'b0;
			if (wr && (addr == `IGCA_ADDR_SRC) && !ser_reg)
				src_next = wdata[0];
		end
		// A new turn-on must pass the fault and 4 mA pressure checks.
		if (!fil_reg && fil_next && !allow_on)
			fil_next = 1'b0;
		if (fault_set || fault_reg)
			fil_next = 1'b0;
		if (!fil_next)
			deg_next = 1'b0;
	end

	// Gauge state, fault latch and the sampled pressure.
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			src_reg    <= `IGCA_SRC_COMBINED;
			ser_reg    <= 1'b0;
			fil_reg    <= 1'b0;
			deg_reg    <= 1'b0;
			em_reg     <= 1'b0;
			fault_reg  <= 1'b0;
			lowlim_reg <= `IGCA_LIM_LOW_MAX;
			pres_reg   <= 16'h0000;
		end
		else
		begin
			src_reg   <= src_next;
			ser_reg   <= ser_next;
			fil_reg   <= fil_next;
			deg_reg   <= deg_next;
			em_reg    <= em_next;
			fault_reg <= fault_set | (fault_reg & ~fault_clr);
			if (wr && (addr == `IGCA_ADDR_LOWLIM))
				lowlim_reg <= lim_wr;
			if (pres_valid)
				pres_reg <= pres_value;
		end
	end

	// Stored value of the setting that the keys edit.
	always @*
	begin
		case (sel_reg)
			`IGCA_EDIT_CONTRAST: cur_val = con_reg;
			`IGCA_EDIT_GAS:      cur_val = {3'h0, gas_reg};
			`IGCA_EDIT_UNIT:     cur_val = {5'h00, unit_reg};
			default:             cur_val = {6'h00, mode_reg};
		endcase
	end

	// Up and down move the edit value within the range of the target.
	always @*
	begin
		edit_next = edit_reg;
		if (key_hit_reg[0])
		begin
			case (sel_reg)
				`IGCA_EDIT_CONTRAST:
					if (edit_reg < `IGCA_CONTRAST_MAX)
						edit_next = edit_reg + 7'h01;
				`IGCA_EDIT_GAS:
					edit_next = (edit_reg == `IGCA_GAS_LAST) ? 7'h00
					                                          : edit_reg + 7'h01;
				`IGCA_EDIT_UNIT:
					edit_next = (edit_reg == `IGCA_UNIT_LAST) ? 7'h00
					                                           : edit_reg + 7'h01;
				default:
					edit_next = {6'h00, ~edit_reg[0]};
			endcase
		end
		else if (key_hit_reg[1])
		begin
			case (sel_reg)
				`IGCA_EDIT_CONTRAST:
					if (edit_reg > `IGCA_CONTRAST_MIN)
						edit_next = edit_reg - 7'h01;
				`IGCA_EDIT_GAS:
					edit_next = (edit_reg == 7'h00) ? `IGCA_GAS_LAST
					                                 : edit_reg - 7'h01;
				`IGCA_EDIT_UNIT:
					edit_next = (edit_reg == 7'h00) ? `IGCA_UNIT_LAST
					                                 : edit_reg - 7'h01;
				default:
					edit_next = {6'h00, ~edit_reg[0]};
			endcase
		end
		if (wr && (addr == `IGCA_ADDR_EDITSEL))
			edit_next = 7'h00;
	end

	// Edit target, edit value and the stored display and unit settings.
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sel_reg  <= `IGCA_EDIT_CONTRAST;
			edit_reg <= `IGCA_CONTRAST_RST;
			con_reg  <= `IGCA_CONTRAST_RST;
			gas_reg  <= `IGCA_GAS_RST;
			unit_reg <= `IGCA_UNIT_RST;
			mode_reg <= `IGCA_MODE_RST;
		end
		else
		begin
			if (wr && (addr == `IGCA_ADDR_EDITSEL))
			begin
				sel_reg  <= wdata[1:0];
				edit_reg <= 7'h00;
			end
			else if (key_hit_reg[2])
			begin
				// Confirm stores the edit value and the edit keeps its value.
				case (sel_reg)
					`IGCA_EDIT_CONTRAST: con_reg  <= (edit_reg < `IGCA_CONTRAST_MIN) ?
					                                 `IGCA_CONTRAST_MIN : edit_reg;
					`IGCA_EDIT_GAS:      gas_reg  <= edit_reg[3:0];
					`IGCA_EDIT_UNIT:     unit_reg <= edit_reg[1:0];
					default:             mode_reg <= edit_reg[0];
				endcase
			end
			else
				edit_reg <= edit_next;
			if (wr && (addr == `IGCA_ADDR_EDITSEL))
				edit_reg <= 7'h00;
			else if (!key_hit_reg[2] && (edit_reg == 7'h00) && (cur_val != 7'h00)
			         && !key_hit_reg[0] && !key_hit_reg[1])
				edit_reg <= cur_val;
		end
	end

	// Register read data, valid in the cycle after the strobe.
	always @*
	begin
		rdata_next = 32'h00000000;
		case (addr)
			`IGCA_ADDR_SRC:      rdata_next = {31'h00000000, src_reg};
			`IGCA_ADDR_LOWLIM:   rdata_next = {16'h0000, lowlim_reg};
			`IGCA_ADDR_EDITSEL:  rdata_next = {23'h000000, edit_reg, sel_reg};
			`IGCA_ADDR_SETTINGS: rdata_next = {15'h0000, mode_reg, 2'h0, unit_reg,
			                                   gas_reg, 1'b0, con_reg};
			`IGCA_ADDR_STATUS:   rdata_next = {26'h0000000, ser_reg, fault_reg,
			                                   em_reg, deg_reg, fil_reg, src_reg};
			`IGCA_ADDR_PRES:     rdata_next = {16'h0000, pres_reg};
			default:             rdata_next = 32'h00000000;
		endcase
	end

	// Output flops.
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata       <= 32'h00000000;
			fil_on      <= 1'b0;
			degas_on    <= 1'b0;
			emis_4ma    <= 1'b0;
			measure_en  <= 1'b1;
			fault_msg   <= 1'b0;
			serial_mode <= 1'b0;
			disp_fields <= `IGCA_DISP_STD;
			contrast    <= `IGCA_CONTRAST_RST;
			gas_sel     <= `IGCA_GAS_RST;
			unit_sel    <= `IGCA_UNIT_RST;
		end
		else
		begin
			rdata       <= rd ? rdata_next : 32'h00000000;
			fil_on      <= fil_next;
			degas_on    <= deg_next;
			emis_4ma    <= em_next;
			measure_en  <= !(fault_set || (fault_reg && !fault_clr));
			fault_msg   <= fault_set || (fault_reg && !fault_clr);
			serial_mode <= ser_next;
			disp_fields <= mode_reg ? `IGCA_DISP_DIAG : `IGCA_DISP_STD;
			contrast    <= con_reg;
			gas_sel     <= gas_reg;
			unit_sel    <= unit_reg;
		end
	end

endmodule // igca_arbiter

//--- dv/igca_chk.sv
`timescale 1ns/1ps
// Watches the arbiter outputs for fault, trip and control-source relations.
module igca_chk
(
	input logic        mclk,
	input logic        rstn,
	input logic        ser_cmd_valid,
	input logic [2:0]  ser_cmd_code,
	input logic        pres_valid,
	input logic [15:0] pres_value,
	input logic        emis_fail,
	input logic        fil_on,
	input logic        degas_on,
	input logic        emis_4ma,
	input logic        measure_en,
	input logic        fault_msg,
	input logic        serial_mode,
	input logic [8:0]  disp_fields,
	input logic [6:0]  contrast,
	input logic [1:0]  unit_sel
);
	// All checks share the one clock and its reset.
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// A fault keeps the filament, degas and measurement off.
	chk_fault_all_off: assert property (fault_msg |-> !fil_on && !degas_on && !measure_en)
		else $error("filament or measurement active during fault");
	chk_fail_trips: assert property (emis_fail |=> fault_msg && !fil_on)
		else $error("emission failure did not trip");
	chk_high_trip: assert property (pres_valid && emis_4ma && pres_value > 16'h03E8 |=> fault_msg)
		else $error("high emission sample above limit did not trip");
	chk_degas_needs_fil: assert property ($rose(degas_on) |-> fil_on)
		else $error("degas started without filament");
	// Control-source transitions.
	chk_read_stays: assert property (ser_cmd_valid && ser_cmd_code == 3'h5 && !serial_mode
		|=> !serial_mode)
		else $error("read command switched to serial");
	chk_serial_hold: assert property (serial_mode && !(ser_cmd_valid && ser_cmd_code == 3'h6)
		|=> serial_mode)
		else $error("serial control left without reset");
	chk_serial_off: assert property (ser_cmd_valid && ser_cmd_code == 3'h1
		|=> !serial_mode || !fil_on)
		else $error("serial filament off ignored");
	chk_din_ignored: assert property (serial_mode && !ser_cmd_valid |=> !$rose(fil_on))
		else $error("filament lit without serial command");
	// Settings stay within their ranges.
	chk_disp_mask: assert property (disp_fields == 9'h01F || disp_fields == 9'h1E1)
		else $error("display field mask invalid");
	chk_set_range: assert property (contrast >= 7'h01 && contrast <= 7'h78 && unit_sel <= 2'h2)
		else $error("setting out of range");

	cov_serial: cover property ($rose(serial_mode));
	cov_fault: cover property ($rose(fault_msg));
	cov_degas: cover property ($rose(degas_on));
endmodule // igca_chk

//--- dv/igca_host.sv
`timescale 1ns/1ps
// Host or controller model: drives the discrete pins and issues serial commands.
module igca_host
(
	input  logic       mclk,
	output logic       din_fil_n,
	output logic       din_emis_n,
	output logic       din_degas_n,
	output logic       ser_cmd_valid,
	output logic [2:0] ser_cmd_code,
	output logic       ser_cmd_arg
);
	// Pins start released and no command is pending.
	initial
	begin
		{din_fil_n, din_emis_n, din_degas_n} = 3'h7;
		ser_cmd_valid = 1'b0;
		ser_cmd_code = 3'h7;
		ser_cmd_arg = 1'b0;
	end

	// Levels are held until changed, so under discrete control the filament stays lit only while held low.
	task automatic pins(input logic fil_n, input logic emis_n, input logic degas_n);
		@(posedge mclk);
		din_fil_n <= fil_n;
		din_emis_n <= emis_n;
		din_degas_n <= degas_n;
	endtask

	// One strobe per command; idle code lines are scrambled so stale values cannot help.
	task automatic ser(input logic [2:0] code, input logic arg);
		@(posedge mclk);
		ser_cmd_valid <= 1'b1;
		ser_cmd_code <= code;
		ser_cmd_arg <= arg;
		@(posedge mclk);
		ser_cmd_valid <= 1'b0;
		ser_cmd_code <= ~code;
		ser_cmd_arg <= ~arg;
	endtask
endmodule // igca_host

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "igca_defines.vh"
// Runs the arbiter through discrete, serial and panel control and checks its outputs.
module testbench;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [2:0]  keys_n = 3'h7;
	logic        pres_valid = 1'b0;
	logic [15:0] pres_value = 16'h0000;
	logic        emis_fail = 1'b0;
	logic [31:0] rdata;
	logic        din_fil_n, din_emis_n, din_degas_n, ser_cmd_valid, ser_cmd_arg;
	logic [2:0]  ser_cmd_code;
	logic        fil_on, degas_on, emis_4ma, measure_en, fault_msg, serial_mode;
	logic [8:0]  disp_fields;
	logic [6:0]  contrast;
	logic [3:0]  gas_sel;
	logic [1:0]  unit_sel;
	int          num_errors = 0;
	int          num_checks = 0;
	int          i;

	// The clock toggles every half period.
	always #5 mclk = ~mclk;

	igca_arbiter DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .din_fil_n(din_fil_n), .din_emis_n(din_emis_n),
		.din_degas_n(din_degas_n), .key_up_n(keys_n[0]), .key_down_n(keys_n[1]),
		.key_enter_n(keys_n[2]), .ser_cmd_valid(ser_cmd_valid), .ser_cmd_code(ser_cmd_code),
		.ser_cmd_arg(ser_cmd_arg), .pres_valid(pres_valid), .pres_value(pres_value),
		.emis_fail(emis_fail), .fil_on(fil_on), .degas_on(degas_on), .emis_4ma(emis_4ma),
		.measure_en(measure_en), .fault_msg(fault_msg), .serial_mode(serial_mode),
		.disp_fields(disp_fields), .contrast(contrast), .gas_sel(gas_sel),
		.unit_sel(unit_sel));

	igca_host host (.mclk(mclk), .din_fil_n(din_fil_n), .din_emis_n(din_emis_n),
		.din_degas_n(din_degas_n), .ser_cmd_valid(ser_cmd_valid),
		.ser_cmd_code(ser_cmd_code), .ser_cmd_arg(ser_cmd_arg));

	// Compares a seen value with the expected one and counts the result.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Waits n edges, then lets their updates settle.
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One-cycle register write.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// One-cycle register read; the word is compared in the cycle after the strobe.
	task automatic rdc(input logic [7:0] a, input string name, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask

	// Delivers one pressure sample, then scrambles the idle value.
	task automatic sample(input logic [15:0] v);
		@(posedge mclk);
		pres_valid <= 1'b1;
		pres_value <= v;
		@(posedge mclk);
		pres_valid <= 1'b0;
		pres_value <= ~v;
		cyc(1);
	endtask

	// Presses and releases one panel key long enough to pass the synchronisers.
	task automatic press(input int k);
		@(posedge mclk);
		keys_n[k] <= 1'b0;
		cyc(8);
		keys_n[k] <= 1'b1;
		cyc(8);
	endtask

	// Prints the verdict and ends the run.
	task automatic tally_and_finish;
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence: reset, discrete, serial, panel, then key editing.
	initial
	begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		cyc(1);
		chk("defaults", {contrast, gas_sel, unit_sel, disp_fields}, 22'h05001F);
		chk("start_off", {fil_on, serial_mode}, 2'b00);
		rdc(`IGCA_ADDR_STATUS, "status", 32'h0);
		rdc(8'hFC, "unmapped", 32'h0);
		host.pins(1'b0, 1'b1, 1'b0);
		cyc(8);
		chk("din_on", {fil_on, emis_4ma, degas_on}, 3'b101);
		host.pins(1'b0, 1'b0, 1'b0);
		cyc(8);
		chk("din_emis", emis_4ma, 1'b1);
		host.pins(1'b1, 1'b1, 1'b0);
		cyc(8);
		chk("din_off", {fil_on, degas_on}, 2'b00);
		host.ser(`IGCA_SER_READ, 1'b0);
		cyc(2);
		chk("read_stay", serial_mode, 1'b0);
		host.pins(1'b0, 1'b1, 1'b0);
		cyc(8);
		host.ser(`IGCA_SER_FIL_ON, 1'b0);
		cyc(1);
		chk("ser_take", {serial_mode, fil_on, degas_on}, 3'b110);
		host.pins(1'b1, 1'b0, 1'b1);
		wr_reg(`IGCA_ADDR_SRC, 32'h1);
		cyc(8);
		chk("ser_ignore", {fil_on, emis_4ma}, 2'b10);
		rdc(`IGCA_ADDR_SRC, "src_keep", 32'h0);
		host.ser(`IGCA_SER_SET_EMIS, 1'b1);
		sample(16'h03E8);
		chk("at_limit", {emis_4ma, fil_on, fault_msg}, 3'b110);
		sample(16'h03E9);
		chk("trip", {fil_on, fault_msg, measure_en}, 3'b010);
		host.ser(`IGCA_SER_FIL_ON, 1'b0);
		cyc(1);
		chk("fault_lock", fil_on, 1'b0);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h40);
		host.ser(`IGCA_SER_FIL_ON, 1'b0);
		cyc(1);
		chk("hi_refuse", {fault_msg, fil_on}, 2'b00);
		sample(16'h0100);
		host.ser(`IGCA_SER_FIL_ON, 1'b0);
		cyc(1);
		chk("hi_ok", fil_on, 1'b1);
		host.ser(`IGCA_SER_DEG_ON, 1'b0);
		cyc(1);
		chk("ser_deg_on", degas_on, 1'b1);
		host.ser(`IGCA_SER_DEG_OFF, 1'b0);
		cyc(1);
		chk("ser_deg_off", degas_on, 1'b0);
		host.ser(`IGCA_SER_FIL_OFF, 1'b0);
		cyc(1);
		chk("ser_off", fil_on, 1'b0);
		host.ser(`IGCA_SER_RESET, 1'b0);
		cyc(1);
		chk("ser_reset", serial_mode, 1'b0);
		host.pins(1'b1, 1'b1, 1'b1);
		wr_reg(`IGCA_ADDR_LOWLIM, 32'hFFFF);
		rdc(`IGCA_ADDR_LOWLIM, "lim_clamp", 32'hC350);
		wr_reg(`IGCA_ADDR_LOWLIM, 32'h0200);
		wr_reg(`IGCA_ADDR_SRC, 32'h1);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h01);
		host.pins(1'b1, 1'b0, 1'b1);
		host.ser(`IGCA_SER_FIL_OFF, 1'b0);
		cyc(8);
		chk("panel", {fil_on, emis_4ma, serial_mode}, 3'b100);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h10);
		cyc(1);
		chk("pdeg_on", degas_on, 1'b1);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h20);
		cyc(1);
		chk("pdeg_off", degas_on, 1'b0);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h04);
		cyc(1);
		chk("pemis", emis_4ma, 1'b1);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h08);
		sample(16'h0200);
		chk("low_hold", {fault_msg, fil_on}, 2'b01);
		sample(16'h0201);
		chk("low_trip", {fault_msg, fil_on}, 2'b10);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h40);
		@(posedge mclk);
		emis_fail <= 1'b1;
		@(posedge mclk);
		emis_fail <= 1'b0;
		cyc(1);
		chk("efail", {fault_msg, measure_en}, 2'b10);
		wr_reg(`IGCA_ADDR_FPCMD, 32'h40);
		cyc(1);
		chk("fclear", fault_msg, 1'b0);
		for (i = 0; i < 4; i++)
		begin
			wr_reg(`IGCA_ADDR_EDITSEL, i);
			cyc(4);
			press(i == 0 ? 0 : 1);
			press(2);
		end
		rdc(`IGCA_ADDR_SETTINGS, "keys", 32'h00012F0B);
		chk("diag", disp_fields, 9'h1E1);
		chk("keys_out", {contrast, gas_sel, unit_sel}, 13'h02FE);
		tally_and_finish;
	end
endmodule // testbench

bind igca_arbiter igca_chk u_chk (.mclk(mclk), .rstn(rstn), .ser_cmd_valid(ser_cmd_valid),
	.ser_cmd_code(ser_cmd_code), .pres_valid(pres_valid), .pres_value(pres_value),
	.emis_fail(emis_fail), .fil_on(fil_on), .degas_on(degas_on), .emis_4ma(emis_4ma),
	.measure_en(measure_en), .fault_msg(fault_msg), .serial_mode(serial_mode),
	.disp_fields(disp_fields), .contrast(contrast), .unit_sel(unit_sel));
